/* dv/irfr_frame_src.sv */
// Purpose: far-side model driving the frame levels and the side link clock
// Assumes: frame levels are commanded by the bench
// Notes: side clock stands still outside frames, period 160 ns inside them
`timescale 1ns/1ns
module irfr_frame_src (
  input wire i_rx_req,
  input wire i_tx_req,
  input wire i_hold_clk,
  output logic o_rx_frame,
  output logic o_tx_frame,
  output logic o_side_clk
);
  assign o_rx_frame = i_rx_req;
  assign o_tx_frame = i_tx_req;
  initial o_side_clk = 1'b0;
  // parked low between frames so the timeout path sees no edges
  // a held clock stands still inside a frame to provoke the stall timeout
  always #80 o_side_clk = ((o_rx_frame | o_tx_frame) && !i_hold_clk) ? ~o_side_clk : 1'b0;
endmodule // irfr_frame_src

/* dv/irfr_top_asserts.sv */
// Purpose: port-level checks of the rise, frame and fast plus registers
// Assumes: sees only the ports of irfr_top
// Notes: bound to every irfr_top instance
`timescale 1ns/1ns
module irfr_top_asserts #(
  parameter ADDR_W = 8
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_rx_frame,
  input wire i_tx_frame,
  input wire [31:0] o_rdata,
  input wire [5:0] o_max_rise_cycles,
  input wire o_fast_plus_en,
  input wire o_side_interface_en,
  input wire o_side_timeout_detect_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // only the low half-word lane holds fields
  wire wr_lo = i_wr && !i_addr[1];
  AST_RISE_RST: assert property ($fell(i_sys_rst) |-> o_max_rise_cycles == 6'h02)
    else $error("rise field not two after reset");
  AST_RISE_WR: assert property (wr_lo && i_addr[7:2] == 6'h08 |=>
    o_max_rise_cycles == $past(i_wdata[5:0])) else $error("rise field write lost");
  AST_RISE_RD: assert property (i_rd && i_addr == 8'h20 |=>
    o_rdata == {26'h0, $past(o_max_rise_cycles)}) else $error("rise readback wrong");
  AST_FMP_WR: assert property (wr_lo && i_addr[7:2] == 6'h24 |=>
    o_fast_plus_en == $past(i_wdata[0])) else $error("fast plus enable wrong");
  AST_SIDE_EN: assert property (wr_lo && i_addr[7:2] == 6'h20 |=>
    o_side_interface_en == $past(i_wdata[0])) else $error("side enable wrong");
  AST_TO_EN: assert property (wr_lo && i_addr[7:2] == 6'h20 |=>
    o_side_timeout_detect_en == $past(i_wdata[1])) else $error("timeout en wrong");
  AST_RX_LVL: assert property ((i_rx_frame && o_side_interface_en)[*4] ##0
    (i_rd && i_addr == 8'h80) |=> o_rdata[9]) else $error("rx level not shown");
  AST_TX_LVL: assert property ((i_tx_frame && o_side_interface_en)[*4] ##0
    (i_rd && i_addr == 8'h80) |=> o_rdata[8]) else $error("tx level not shown");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data lingers");
endmodule // irfr_top_asserts
bind irfr_top irfr_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_rx_frame(i_rx_frame),
  .i_tx_frame(i_tx_frame), .o_rdata(o_rdata), .o_max_rise_cycles(o_max_rise_cycles),
  .o_fast_plus_en(o_fast_plus_en), .o_side_interface_en(o_side_interface_en),
  .o_side_timeout_detect_en(o_side_timeout_detect_en));

/* dv/irfr_top_tb_top.sv */
// Purpose: self-checking bench for the rise, frame and fast plus registers
// Assumes: one-cycle strobes, read data the cycle after the read strobe
// Notes: frame levels come from irfr_frame_src
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module irfr_top_tb_top;
  logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_half = 0, rx_req = 0, tx_req = 0;
  logic hold_clk = 0;
  logic [7:0] i_addr = 0;
  logic [31:0] i_wdata = 0;
  wire [31:0] o_rdata;
  wire [5:0] o_max_rise_cycles;
  wire o_irq, o_fast_plus_en, o_side_interface_en, o_side_timeout_detect_en;
  wire rx_f, tx_f, side_clk;
  int error_cnt = 0;
  int tests_run = 0;
  always #4 i_clk = ~i_clk;
  irfr_frame_src u_src (.i_rx_req(rx_req), .i_tx_req(tx_req), .i_hold_clk(hold_clk),
    .o_rx_frame(rx_f),
    .o_tx_frame(tx_f), .o_side_clk(side_clk));
  irfr_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_half(i_half), .i_rx_frame(rx_f), .i_tx_frame(tx_f),
    .i_side_clk(side_clk), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_max_rise_cycles(o_max_rise_cycles), .o_fast_plus_en(o_fast_plus_en),
    .o_side_interface_en(o_side_interface_en),
    .o_side_timeout_detect_en(o_side_timeout_detect_en));
  task wr(input [7:0] a, input [31:0] d, input h = 1'b0);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_half <= h;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a, input [31:0] e, input string n);
    @(posedge i_clk);
    i_addr <= a;
    i_half <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(n, e, o_rdata)
  endtask
  // frame edges need three cycles to show, six keeps pulses well apart
  task fr(input r, input t);
    @(posedge i_clk);
    rx_req <= r;
    tx_req <= t;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task t_reset;
    rd(8'h20, 32'h2, "rise_time_limit");
    rd(8'h80, 32'h0, "frame_side_ctrl_status");
    rd(8'h90, 32'h0, "fast_plus_config");
    $display("test reset done");
  endtask
  task t_rise;
    wr(8'h20, 32'h3f);
    rd(8'h20, 32'h3f, "rise word");
    wr(8'h20, 32'h15, 1'b1);
    rd(8'h20, 32'h15, "rise half");
    `CHK("max_rise_cycles", 6'h15, o_max_rise_cycles)
    wr(8'h90, 32'h1, 1'b1);
    `CHK("fast_plus_en", 1'b1, o_fast_plus_en)
    rd(8'h90, 32'h1, "fast plus half");
    wr(8'h90, 32'h0);
    `CHK("fast_plus_en off", 1'b0, o_fast_plus_en)
    rd(8'h40, 32'h0, "unmapped");
    $display("test rise done");
  endtask
  task t_frame;
    wr(8'h80, 32'hf3);
    `CHK("side_interface_en", 1'b1, o_side_interface_en)
    `CHK("side_timeout_detect_en", 1'b1, o_side_timeout_detect_en)
    fr(1, 0);
    rd(8'h80, 32'h82f3, "rx rise");
    `CHK("irq rx rise", 1'b1, o_irq)
    fr(1, 1);
    rd(8'h80, 32'ha3f3, "tx rise");
    fr(0, 0);
    rd(8'h80, 32'hf0f3, "falls");
    rd(8'h84, 32'hf, "irq status");
    wr(8'h88, 32'hf);
    rd(8'h84, 32'h0, "irq status cleared");
    `CHK("irq cleared", 1'b0, o_irq)
    fr(1, 0);
    // flag bits written as zero clear them
    wr(8'h80, 32'hf3);
    rd(8'h80, 32'h2f3, "write zero clears");
    wr(8'h80, 32'h3);
    fr(0, 0);
    `CHK("irq masked", 1'b0, o_irq)
    rd(8'h80, 32'h4003, "masked flag");
    wr(8'h80, 32'h4043);
    @(posedge i_clk);
    #1;
    `CHK("irq unmasked", 1'b1, o_irq)
    wr(8'h80, 32'h0);
    fr(1, 1);
    rd(8'h80, 32'h0, "interface off");
    fr(0, 0);
    wr(8'h80, 32'h11);
    fr(0, 1);
    `CHK("irq tx rise masked", 1'b0, o_irq)
    fr(0, 0);
    `CHK("irq tx fall", 1'b1, o_irq)
    rd(8'h8c, 32'h1, "irq enable alias");
    rd(8'h84, 32'h3, "tx flags");
    wr(8'h88, 32'h1f);
    rd(8'h84, 32'h0, "tx flags cleared");
    $display("test frame done");
  endtask
  // side clock held while rx frame stays open; stall limit is 3125 clocks
  task t_timeout;
    wr(8'h8c, 32'h10);
    wr(8'h80, 32'h3);
    @(posedge i_clk);
    hold_clk <= 1'b1;
    fr(1, 0);
    repeat (3125) @(posedge i_clk);
    #1;
    rd(8'h84, 32'h18, "timeout flag");
    `CHK("irq timeout", 1'b1, o_irq)
    wr(8'h88, 32'h1f);
    rd(8'h84, 32'h0, "timeout cleared");
    @(posedge i_clk);
    hold_clk <= 1'b0;
    fr(0, 0);
    $display("test timeout done");
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_rise;
    t_frame;
    t_timeout;
    report_and_stop;
  end
endmodule // irfr_top_tb_top

/* hdl/irfr_regs.vh */
// Purpose: offsets, field positions, reset values and timing for the frame/rise/fmp registers
// Assumes: byte addresses on an 8-bit register port, 125 MHz system clock
// Notes: included by bare name from the design files
`ifndef IRFR_REGS_VH
`define IRFR_REGS_VH

`define IRFR_AW 8
`define IRFR_OFF_RISE_TIME 8'h20
`define IRFR_OFF_FRAME_CTRL 8'h80
`define IRFR_OFF_IRQ_STATUS 8'h84
`define IRFR_OFF_IRQ_CLEAR 8'h88
`define IRFR_OFF_IRQ_ENABLE 8'h8c
`define IRFR_OFF_FAST_PLUS 8'h90

`define IRFR_RISE_TIME_RST 6'h02
`define IRFR_RISE_TIME_W 6

// frame control/status field positions
`define IRFR_FLAG_HI 15
`define IRFR_FLAG_LO 12
`define IRFR_RX_LEVEL_BIT 9
`define IRFR_TX_LEVEL_BIT 8
`define IRFR_IEN_HI 7
`define IRFR_IEN_LO 4
`define IRFR_TIMEOUT_EN_BIT 1
`define IRFR_SIDE_EN_BIT 0

// interrupt status, clear and enable share this layout
`define IRFR_IRQ_EDGE_HI 3
`define IRFR_IRQ_EDGE_LO 0
`define IRFR_IRQ_TIMEOUT_BIT 4

`define IRFR_FAST_PLUS_BIT 0

`define IRFR_CLK_MHZ 125
`define IRFR_TIMEOUT_NS 25000
`define IRFR_TIMEOUT_CW 12

`endif

/* hdl/irfr_sync.v */
// Purpose: two-flop synchroniser with edge detection for slow side-band signals
// Assumes: inputs change far slower than i_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module irfr_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_level,
  output wire [W-1:0] o_rise,
  output wire [W-1:0] o_fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      prev_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule // irfr_sync

/* hdl/irfr_top.v */
// Purpose: rise time, side frame interface and fast mode plus registers of an i2c controller
// Assumes: register port with one-cycle strobes, read data one cycle after the read strobe
// Notes: frame signals and side clock are asynchronous and are synchronised here
//
// How it works
// - rise time register resets to two, upper bits zero
// - rise time and fast plus registers accept half-word and word access
// - bit 15 flags receive frame rising edge, cleared by writing zero
// - bit 14 flags receive frame falling edge, cleared by writing zero
// - bit 13 flags transmit frame rising edge, cleared by writing zero
// - bit 12 flags transmit frame falling edge, cleared by writing zero
// - read-only bit 9 shows receive frame level
// - read-only bit 8 shows transmit frame level
// - bits 7 and 6 enable receive rise and fall interrupts
// - bits 5 and 4 enable transmit rise and fall interrupts
// - bit 1 enables side interface timeout detection
// - bit 0 enables the side frame interface entirely
// - fast plus bit allows bus rates up to 1MHz
`timescale 1ns/1ns
`include "irfr_regs.vh"
module irfr_top #(
  parameter ADDR_W = `IRFR_AW
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_half,
  input wire i_rx_frame,
  input wire i_tx_frame,
  input wire i_side_clk,
  output reg [31:0] o_rdata,
  output reg o_irq,
  output reg [`IRFR_RISE_TIME_W-1:0] o_max_rise_cycles,
  output reg o_fast_plus_en,
  output reg o_side_interface_en,
  output reg o_side_timeout_detect_en
);
  // stall limit in system clocks; must fit the counter width
  localparam integer TIMEOUT_CYC_I = (`IRFR_TIMEOUT_NS * `IRFR_CLK_MHZ) / 1000;
  localparam [`IRFR_TIMEOUT_CW-1:0] TIMEOUT_CYC = TIMEOUT_CYC_I[`IRFR_TIMEOUT_CW-1:0];

  // byte offsets held at full address width before the lane bits are dropped
  localparam [7:0] OFF_RISE = `IRFR_OFF_RISE_TIME;
  localparam [7:0] OFF_CTRL = `IRFR_OFF_FRAME_CTRL;
  localparam [7:0] OFF_STAT = `IRFR_OFF_IRQ_STATUS;
  localparam [7:0] OFF_CLR = `IRFR_OFF_IRQ_CLEAR;
  localparam [7:0] OFF_IEN = `IRFR_OFF_IRQ_ENABLE;
  localparam [7:0] OFF_FMP = `IRFR_OFF_FAST_PLUS;

  // word numbers; both lanes of a word share one number
  localparam [ADDR_W-3:0] WRD_RISE = OFF_RISE[ADDR_W-1:2];
  localparam [ADDR_W-3:0] WRD_CTRL = OFF_CTRL[ADDR_W-1:2];
  localparam [ADDR_W-3:0] WRD_STAT = OFF_STAT[ADDR_W-1:2];
  localparam [ADDR_W-3:0] WRD_CLR = OFF_CLR[ADDR_W-1:2];
  localparam [ADDR_W-3:0] WRD_IEN = OFF_IEN[ADDR_W-1:2];
  localparam [ADDR_W-3:0] WRD_FMP = OFF_FMP[ADDR_W-1:2];

  // lane mask of an access; half-words use the lane picked by address bit 1
  function [31:0] lane_mask;
    input half;
    input a1;
    begin
      if (!half)
        lane_mask = 32'hffffffff;
      else if (a1)
        lane_mask = 32'hffff0000;
      else
        lane_mask = 32'h0000ffff;
    end
  endfunction

  // word match of a strobe; shared by every write decode
  function word_hit;
    input strobe;
    input [ADDR_W-3:0] word;
    input [ADDR_W-3:0] target;
    begin
      word_hit = strobe && (word == target);
    end
  endfunction

  // register state and next values
  reg [`IRFR_RISE_TIME_W-1:0] rise_q;
  reg [`IRFR_RISE_TIME_W-1:0] rise_d;
  reg fmp_q;
  reg fmp_d;
  reg side_en_q;
  reg side_en_d;
  reg to_en_q;
  reg to_en_d;
  reg [3:0] ien_q;
  reg [3:0] ien_d;
  reg to_ien_q;
  reg to_ien_d;
  reg [3:0] flag_q;
  reg [3:0] flag_d;
  reg to_flag_q;
  reg to_flag_d;
  reg [`IRFR_TIMEOUT_CW-1:0] to_cnt_q;
  reg [`IRFR_TIMEOUT_CW-1:0] to_cnt_d;
  reg [31:0] rdata_d;
  reg irq_d;

  // decode and event nets
  wire [ADDR_W-3:0] word_sel;
  wire [31:0] wmask;
  wire [31:0] wval;
  wire wr_rise;
  wire wr_fmp;
  wire wr_ctrl;
  wire wr_clr;
  wire wr_ien;
  wire [1:0] frame_lvl;
  wire [1:0] frame_rise;
  wire [1:0] frame_fall;
  wire sclk_rise;
  wire sclk_fall;
  wire [3:0] edge_evt;
  wire [3:0] ctrl_clr;
  wire [3:0] stat_clr;
  wire [1:0] shown_lvl;
  wire frame_busy;
  wire [3:0] edge_pend;
  wire to_pend;

  // rx in the upper bit, tx in the lower, matching the flag order
  irfr_sync #(
    .W(2)
  ) u_frame_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_rx_frame, i_tx_frame}),
    .o_level(frame_lvl),
    .o_rise(frame_rise),
    .o_fall(frame_fall)
  );

  // side clock is only edge-detected; its level is never read
  irfr_sync #(
    .W(1)
  ) u_sclk_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_side_clk),
    .o_level(),
    .o_rise(sclk_rise),
    .o_fall(sclk_fall)
  );

  assign wmask = lane_mask(i_half, i_addr[1]);
  assign wval = i_wdata & wmask;
  assign word_sel = i_addr[ADDR_W-1:2];
  assign wr_rise = word_hit(i_wr, word_sel, WRD_RISE);
  assign wr_fmp = word_hit(i_wr, word_sel, WRD_FMP);
  assign wr_ctrl = word_hit(i_wr, word_sel, WRD_CTRL);
  assign wr_clr = word_hit(i_wr, word_sel, WRD_CLR);
  assign wr_ien = word_hit(i_wr, word_sel, WRD_IEN);

  assign edge_evt = side_en_q ? {frame_rise[1], frame_fall[1], frame_rise[0], frame_fall[0]}
                              : 4'h0;

  // control writes of zero and clear writes of one clear flags, only in written lanes
  assign ctrl_clr = wr_ctrl ? (wmask[`IRFR_FLAG_HI:`IRFR_FLAG_LO] &
                               ~i_wdata[`IRFR_FLAG_HI:`IRFR_FLAG_LO]) : 4'h0;
  assign stat_clr = wr_clr ? wval[`IRFR_IRQ_EDGE_HI:`IRFR_IRQ_EDGE_LO] : 4'h0;

  assign shown_lvl = side_en_q ? frame_lvl : 2'b00;
  assign frame_busy = frame_lvl[1] | frame_lvl[0];

  // pending sources seen with the next state, so irq is not a cycle late
  assign edge_pend = flag_d & ien_d;
  assign to_pend = to_flag_d & to_ien_d;

  // write decode: a half-word to the upper lane only hits reserved bits
  always @*
  begin
    rise_d = rise_q;
    fmp_d = fmp_q;
    side_en_d = side_en_q;
    to_en_d = to_en_q;
    ien_d = ien_q;
    to_ien_d = to_ien_q;
    if (wr_rise && wmask[0])
    begin
      rise_d = i_wdata[`IRFR_RISE_TIME_W-1:0];
    end
    if (wr_fmp && wmask[0])
    begin
      fmp_d = i_wdata[`IRFR_FAST_PLUS_BIT];
    end
    if (wr_ctrl && wmask[0])
    begin
      side_en_d = i_wdata[`IRFR_SIDE_EN_BIT];
      to_en_d = i_wdata[`IRFR_TIMEOUT_EN_BIT];
      ien_d = i_wdata[`IRFR_IEN_HI:`IRFR_IEN_LO];
    end
    if (wr_ien && wmask[0])
    begin
      ien_d = i_wdata[`IRFR_IRQ_EDGE_HI:`IRFR_IRQ_EDGE_LO];
      to_ien_d = i_wdata[`IRFR_IRQ_TIMEOUT_BIT];
    end
  end

  always @*
  begin
    flag_d = (flag_q & ~(ctrl_clr | stat_clr)) | edge_evt;
    to_cnt_d = to_cnt_q;
    to_flag_d = to_flag_q;
    if (wr_clr && wval[`IRFR_IRQ_TIMEOUT_BIT])
    begin
      to_flag_d = 1'b0;
    end
    // side clock stall while a frame is open
    if (!side_en_q || !to_en_q || !frame_busy || sclk_rise || sclk_fall)
    begin
      to_cnt_d = {`IRFR_TIMEOUT_CW{1'b0}};
    end
    // saturate so a stalled frame flags only once
    else if (to_cnt_q != TIMEOUT_CYC)
    begin
      to_cnt_d = to_cnt_q + {{(`IRFR_TIMEOUT_CW-1){1'b0}}, 1'b1};
      if (to_cnt_d == TIMEOUT_CYC)
      begin
        to_flag_d = 1'b1;
      end
    end
  end

  // read data is zero outside the read cycle so slaves can be or-ed
  always @*
  begin
    rdata_d = 32'h00000000;
    if (i_rd)
    begin
      // unmapped and write-only words read zero
      case (word_sel)
        WRD_RISE:
        begin
          rdata_d[`IRFR_RISE_TIME_W-1:0] = rise_q;
        end
        WRD_CTRL:
        begin
          rdata_d[`IRFR_FLAG_HI:`IRFR_FLAG_LO] = flag_q;
          rdata_d[`IRFR_RX_LEVEL_BIT] = shown_lvl[1];
          rdata_d[`IRFR_TX_LEVEL_BIT] = shown_lvl[0];
          rdata_d[`IRFR_IEN_HI:`IRFR_IEN_LO] = ien_q;
          rdata_d[`IRFR_TIMEOUT_EN_BIT] = to_en_q;
          rdata_d[`IRFR_SIDE_EN_BIT] = side_en_q;
        end
        WRD_STAT:
        begin
          rdata_d[`IRFR_IRQ_EDGE_HI:`IRFR_IRQ_EDGE_LO] = flag_q;
          rdata_d[`IRFR_IRQ_TIMEOUT_BIT] = to_flag_q;
        end
        WRD_IEN:
        begin
          rdata_d[`IRFR_IRQ_EDGE_HI:`IRFR_IRQ_EDGE_LO] = ien_q;
          rdata_d[`IRFR_IRQ_TIMEOUT_BIT] = to_ien_q;
        end
        WRD_FMP:
        begin
          rdata_d[`IRFR_FAST_PLUS_BIT] = fmp_q;
        end
        default:
        begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
    irq_d = (|edge_pend) | to_pend;
  end

  // one clocked process; reset is synchronous like the bus
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rise_q <= `IRFR_RISE_TIME_RST;
      fmp_q <= 1'b0;
      side_en_q <= 1'b0;
      to_en_q <= 1'b0;
      ien_q <= 4'h0;
      to_ien_q <= 1'b0;
      flag_q <= 4'h0;
      to_flag_q <= 1'b0;
      to_cnt_q <= {`IRFR_TIMEOUT_CW{1'b0}};
      o_rdata <= 32'h00000000;
      o_irq <= 1'b0;
      o_max_rise_cycles <= `IRFR_RISE_TIME_RST;
      o_fast_plus_en <= 1'b0;
      o_side_interface_en <= 1'b0;
      o_side_timeout_detect_en <= 1'b0;
    end
    else
    begin
      rise_q <= rise_d;
      fmp_q <= fmp_d;
      side_en_q <= side_en_d;
      to_en_q <= to_en_d;
      ien_q <= ien_d;
      to_ien_q <= to_ien_d;
      flag_q <= flag_d;
      to_flag_q <= to_flag_d;
      to_cnt_q <= to_cnt_d;
      o_rdata <= rdata_d;
      o_irq <= irq_d;
      // outputs track the next register value so they match the register bits
      o_max_rise_cycles <= rise_d;
      o_fast_plus_en <= fmp_d;
      o_side_interface_en <= side_en_d;
      o_side_timeout_detect_en <= to_en_d;
    end
  end
endmodule // irfr_top
